//--- core/mbr_pkg.sv
// Shared constants for the mixer and bus routing block
package mbr_pkg;
  // Sample and mixer geometry
  localparam int SW     = 16;  // Sample width
  localparam int NCH    = 4;   // Preamp 1, 2, virtual 1, 2
  localparam int NPRE   = 2;   // Preamp channels
  localparam int NAUX   = 2;   // Aux buses and aux returns
  localparam int NSRC   = 6;   // Input channels then aux returns
  localparam int NBUS   = 4;   // Monitor, aux 1, aux 2, cue
  localparam int NENT   = 24;  // Send entries, source * 4 + bus
  localparam int ACC_W  = 20;  // Bus accumulator width
  localparam int ADDR_W = 8;   // APB address width
  localparam int CTRL_W = 16;  // Control register width
  localparam int ENT_W  = 17;  // Send entry width

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] TAB_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] TAB_END  = 8'ha0;

  // Control register fields
  localparam int CB_LINE   = 0;   // Two bits, 1 selects line over mic
  localparam int CB_WET    = 2;   // Four bits, per-channel wet record
  localparam int CB_GAPPLY = 6;   // Global record setting applied
  localparam int CB_GWET   = 7;   // Global wet record value
  localparam int CB_HPCUE  = 8;   // Headphones take the cue bus
  localparam int CB_MONCUE = 9;   // Monitor outputs take the cue bus
  localparam int CB_MUTE   = 10;  // Monitor outputs muted
  localparam int CB_MONO   = 11;  // Monitor outputs mono-summed
  localparam int CB_AUXPRE = 12;  // Two bits, aux tap before fader
  localparam int CB_LINK   = 14;  // Two bits, stereo link per pair
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;

  // Status register fields
  localparam int SB_INST = 0;  // Channel 1 on instrument jack
  localparam int SB_BUSY = 1;  // Mix frame in progress

  // Send entry fields and reset value
  localparam int TB_LVL  = 0;
  localparam int TB_PAN  = 8;
  localparam int TB_MUTE = 16;
  localparam logic [ENT_W-1:0] TAB_RST = 17'h080c0;

  // Bus numbers, step limits and pan weights
  localparam logic [1:0] BUS_MON  = 2'h0;
  localparam logic [1:0] BUS_AUX1 = 2'h1;
  localparam logic [1:0] BUS_AUX2 = 2'h2;
  localparam logic [1:0] BUS_CUE  = 2'h3;
  localparam logic [4:0] LAST_IDX = 5'h17;
  localparam logic [2:0] AUXRET0  = 3'h4;
  localparam logic [7:0] W_FULL   = 8'hff;
  localparam logic [7:0] W_NONE   = 8'h00;

  // Saturation limits
  localparam logic signed [ACC_W-1:0] ACC_MAX = 20'sh07fff;
  localparam logic signed [ACC_W-1:0] ACC_MIN = 20'shf8000;
  localparam logic signed [SW-1:0]    S_MAX   = 16'sh7fff;
  localparam logic signed [SW-1:0]    S_MIN   = 16'sh8000;

  // Mix engine states
  typedef enum {ST_IDLE, ST_RUN, ST_DONE} mbr_state_t;
endpackage : mbr_pkg

//--- core/mbr_mixer.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// [RULE1] Two preamp channels with selectable sources
// [RULE2] Mic/line changes only on explicit command
// [RULE3] Channel 1 follows instrument jack plug
// [RULE4] Virtual inputs take host playback samples
// [RULE5] Modelling slot plus insert chain per channel (the code has a modelling slot on preamp channels 1 and 2 only)
// [RULE6] Modelling slot precedes standard inserts
// [RULE7] Record tap after or before inserts
// [RULE8] Modelling slot always recorded; aux returns are not recorded, only mixed
// [RULE9] Per-channel record choice, global override
// [RULE10] Four stereo buses, level pan mute each
// [RULE11] Cue sends taken before fader and mute
// [RULE12] Linked pairs cue hard left/right
// [RULE13] Headphones carry monitor mix unless cue
// [RULE14] Monitor outputs may carry cue bus
// [RULE15] Aux post-fader default, pre selectable
// [RULE16] Exactly one stereo cue bus
// [RULE17] Inputs always summed to monitor unless muted
// [RULE18] Monitor mute and mono independent
// [RULE19] Bus sums saturate, never wrap
module mbr_mixer (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic [mbr_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Frame strobe
  input  wire logic                       sample_tick,
  // Preamp sources and front panel
  input  wire logic signed [15:0]         mic_in [2],
  input  wire logic signed [15:0]         line_in [2],
  input  wire logic signed [15:0]         instrument_input,
  input  wire logic                       inst_plug,
  input  wire logic [1:0]                 panel_stb,
  input  wire logic [1:0]                 panel_line,
  // Host playback for virtual inputs
  input  wire logic signed [15:0]         virt_in [2],
  // Modelling slot
  input  wire logic [1:0]                 model_occupied,
  input  wire logic signed [15:0]         model_ret [2],
  output logic signed [15:0]              model_send [2],
  // Insert chains and aux returns
  input  wire logic signed [15:0]         ins_ret [4],
  output logic signed [15:0]              ins_send [4],
  input  wire logic signed [15:0]         aux_ret_l [2],
  input  wire logic signed [15:0]         aux_ret_r [2],
  // Record feeds and bus outputs
  output logic signed [15:0]              rec_out [4],
  output logic signed [15:0]              aux_l [2],
  output logic signed [15:0]              aux_r [2],
  output logic signed [15:0]              mon_l,
  output logic signed [15:0]              mon_r,
  output logic signed [15:0]              hp_l,
  output logic signed [15:0]              hp_r
);

  // Scale a sample by an 8-bit gain of g/256
  function automatic logic signed [15:0] scale(input logic signed [15:0] s, input logic [7:0] g);
    logic signed [24:0] p;
    p = s * $signed({1'b0, g});
    return p[23:8];
  endfunction : scale

  // Clip an accumulator to sample range
  function automatic logic signed [15:0] sat(input logic signed [mbr_pkg::ACC_W-1:0] a);
    if (a > mbr_pkg::ACC_MAX)
      return mbr_pkg::S_MAX;
    else if (a < mbr_pkg::ACC_MIN)
      return mbr_pkg::S_MIN;
    else
      return a[15:0];
  endfunction : sat

  // Register state
  logic [mbr_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;         // Control word
  logic [mbr_pkg::ENT_W-1:0]  tab_q [mbr_pkg::NENT];  // Send entries
  logic [mbr_pkg::ENT_W-1:0]  tab_d [mbr_pkg::NENT];
  logic [31:0]                prdata_q, prdata_d;     // Read data
  logic                       pready_q, pready_d;     // Access answer
  logic                       pslverr_q, pslverr_d;   // Unmapped answer
  logic                       wr_en;                  // Write completes now
  logic                       tab_hit;                // Address in table
  logic [4:0]                 tab_idx;                // Table entry index
  logic [mbr_pkg::ADDR_W-1:0] tab_off;                // Offset into table

  // Mix engine state
  mbr_pkg::mbr_state_t        st_q, st_d;
  logic [4:0]                 idx_q, idx_d;           // Step: source * 4 + bus
  logic signed [mbr_pkg::ACC_W-1:0] acc_q [mbr_pkg::NBUS][2];
  logic signed [mbr_pkg::ACC_W-1:0] acc_d [mbr_pkg::NBUS][2];
  logic signed [15:0]         smp_q [mbr_pkg::NSRC];  // Frame snapshot
  logic signed [15:0]         smp_d [mbr_pkg::NSRC];
  logic signed [15:0]         bus_sat [mbr_pkg::NBUS][2];

  // Output flops
  logic signed [15:0]         msend_q [2], msend_d [2];
  logic signed [15:0]         isend_q [4], isend_d [4];
  logic signed [15:0]         rec_q [4], rec_d [4];
  logic signed [15:0]         auxl_q [2], auxl_d [2];
  logic signed [15:0]         auxr_q [2], auxr_d [2];
  logic signed [15:0]         monl_q, monl_d, monr_q, monr_d;
  logic signed [15:0]         hpl_q, hpl_d, hpr_q, hpr_d;

  // Per-step datapath and frame helpers
  logic [2:0]                 si;                     // Source of step
  logic [1:0]                 bi;                     // Bus of step
  logic [mbr_pkg::ENT_W-1:0]  ent;                    // Entry of step
  logic [mbr_pkg::ENT_W-1:0]  fad;                    // Source fader entry
  logic signed [15:0]         sv;                     // Send after gain
  logic [7:0]                 wt_l, wt_r;             // Pan weights
  logic signed [15:0]         tl, tr;                 // Panned terms
  logic signed [15:0]         src [2];                // Selected preamp source
  logic signed [15:0]         pre [4];                // Pre-insert signal
  logic [3:0]                 eff_wet;                // Effective record choice
  logic signed [16:0]         msum;                   // Mono sum
  logic signed [15:0]         ml, mr;                 // Monitor output pair
  logic signed [16:0]         rsum [mbr_pkg::NAUX];   // Aux return pair sums

  // APB decode, control and table next values
  always_comb
  begin
    ctrl_d    = ctrl_q;
    tab_d     = tab_q;
    prdata_d  = 32'h0000_0000;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    wr_en     = psel & penable & pready_q & pwrite;
    tab_off   = paddr - mbr_pkg::TAB_BASE;
    tab_idx   = tab_off[6:2];
    tab_hit   = (paddr >= mbr_pkg::TAB_BASE) && (paddr < mbr_pkg::TAB_END) && (paddr[1:0] == 2'h0);
    // Front panel source commands
    for (int c = 0; c < mbr_pkg::NPRE; c++)
      if (panel_stb[c])
        ctrl_d[mbr_pkg::CB_LINE + c] = panel_line[c];  // [RULE2]
    // Host writes take effect at the completing edge, over the panel
    if (wr_en && paddr == mbr_pkg::CTRL_OFF)
      ctrl_d = pwdata[mbr_pkg::CTRL_W-1:0];  // [RULE2]
    if (wr_en && tab_hit)
      tab_d[tab_idx] = pwdata[mbr_pkg::ENT_W-1:0];  // [RULE10]
    // Setup cycle prepares the one-cycle access answer
    if (psel && !penable)
    begin
      pready_d = 1'b1;
      if (paddr == mbr_pkg::CTRL_OFF)
        prdata_d = {16'h0000, ctrl_q};
      else if (paddr == mbr_pkg::STAT_OFF)
      begin
        prdata_d[mbr_pkg::SB_INST] = inst_plug;
        prdata_d[mbr_pkg::SB_BUSY] = (st_q != mbr_pkg::ST_IDLE);
      end
      else if (tab_hit)
        prdata_d = {15'h0000, tab_q[tab_idx]};
      else
        pslverr_d = 1'b1;
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= mbr_pkg::CTRL_RST;  // [RULE13]
      tab_q     <= '{default: mbr_pkg::TAB_RST};
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      tab_q     <= tab_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Source selection, record taps and one mix step
  always_comb
  begin
    for (int c = 0; c < mbr_pkg::NPRE; c++)
    begin
      src[c] = ctrl_q[mbr_pkg::CB_LINE + c] ? line_in[c] : mic_in[c];  // [RULE1]
      pre[c] = model_occupied[c] ? model_ret[c] : src[c];  // [RULE6] [RULE8]
    end
    if (inst_plug)
      src[0] = instrument_input;  // [RULE3]
    if (inst_plug && !model_occupied[0])
      pre[0] = instrument_input;  // [RULE3]
    for (int v = 0; v < 2; v++)
      pre[mbr_pkg::NPRE + v] = virt_in[v];  // [RULE4]
    for (int k = 0; k < mbr_pkg::NAUX; k++)
      rsum[k] = {aux_ret_l[k][15], aux_ret_l[k]} + {aux_ret_r[k][15], aux_ret_r[k]};
    for (int i = 0; i < mbr_pkg::NCH; i++)
      eff_wet[i] = ctrl_q[mbr_pkg::CB_GAPPLY] ? ctrl_q[mbr_pkg::CB_GWET] : ctrl_q[mbr_pkg::CB_WET + i];  // [RULE9]
    // One send term per step
    si  = idx_q[4:2];
    bi  = idx_q[1:0];
    ent = tab_q[idx_q];
    fad = tab_q[{si, 2'h0}];
    sv  = ent[mbr_pkg::TB_MUTE] ? 16'sh0000 : scale(smp_q[si], ent[mbr_pkg::TB_LVL +: 8]);  // [RULE17] [RULE11]
    if (bi == mbr_pkg::BUS_AUX1 || bi == mbr_pkg::BUS_AUX2)
    begin
      if (si >= mbr_pkg::AUXRET0)
        sv = 16'sh0000;  // Aux returns do not feed aux buses
      else if (!ctrl_q[mbr_pkg::CB_AUXPRE + int'(bi) - 1])
        sv = fad[mbr_pkg::TB_MUTE] ? 16'sh0000 : scale(sv, fad[mbr_pkg::TB_LVL +: 8]);  // [RULE15]
    end
    wt_l = mbr_pkg::W_FULL - ent[mbr_pkg::TB_PAN +: 8];
    wt_r = ent[mbr_pkg::TB_PAN +: 8];
    if (bi == mbr_pkg::BUS_CUE && si < mbr_pkg::AUXRET0 && ctrl_q[mbr_pkg::CB_LINK + int'(si[1])])
    begin
      wt_l = si[0] ? mbr_pkg::W_NONE : mbr_pkg::W_FULL;  // [RULE12]
      wt_r = si[0] ? mbr_pkg::W_FULL : mbr_pkg::W_NONE;  // [RULE12]
    end
    tl = scale(sv, wt_l);
    tr = scale(sv, wt_r);
    for (int b = 0; b < mbr_pkg::NBUS; b++)
      for (int k = 0; k < 2; k++)
        bus_sat[b][k] = sat(acc_q[b][k]);  // [RULE19]
    // Monitor output source, mono and mute
    ml = ctrl_q[mbr_pkg::CB_MONCUE] ? bus_sat[mbr_pkg::BUS_CUE][0] : bus_sat[mbr_pkg::BUS_MON][0];  // [RULE14]
    mr = ctrl_q[mbr_pkg::CB_MONCUE] ? bus_sat[mbr_pkg::BUS_CUE][1] : bus_sat[mbr_pkg::BUS_MON][1];  // [RULE14]
    msum = {ml[15], ml} + {mr[15], mr};
    if (ctrl_q[mbr_pkg::CB_MONO])
    begin
      ml = msum[16:1];  // [RULE18]
      mr = msum[16:1];
    end
    if (ctrl_q[mbr_pkg::CB_MUTE])
    begin
      ml = 16'sh0000;  // [RULE18]
      mr = 16'sh0000;
    end
  end

  // Mix engine next values
  always_comb
  begin
    st_d    = st_q;
    idx_d   = idx_q;
    acc_d   = acc_q;
    smp_d   = smp_q;
    msend_d = msend_q;
    isend_d = isend_q;
    rec_d   = rec_q;
    auxl_d  = auxl_q;
    auxr_d  = auxr_q;
    monl_d  = monl_q;
    monr_d  = monr_q;
    hpl_d   = hpl_q;
    hpr_d   = hpr_q;
    unique case (st_q)
      // Snapshot a frame and refresh sends and record feeds
      mbr_pkg::ST_IDLE:
        if (sample_tick)
        begin
          for (int c = 0; c < mbr_pkg::NPRE; c++)
            msend_d[c] = src[c];  // [RULE5]
          for (int i = 0; i < mbr_pkg::NCH; i++)
          begin
            isend_d[i] = pre[i];  // [RULE5] [RULE6]
            rec_d[i]   = eff_wet[i] ? ins_ret[i] : pre[i];  // [RULE7] [RULE8]
            smp_d[i]   = ins_ret[i];
          end
          for (int k = 0; k < mbr_pkg::NAUX; k++)
            smp_d[mbr_pkg::NCH + k] = rsum[k][16:1];  // [RULE8]
          acc_d = '{default: '0};
          idx_d = 5'h00;
          st_d  = mbr_pkg::ST_RUN;
        end
      // Accumulate one source into one bus per cycle
      mbr_pkg::ST_RUN:
      begin
        acc_d[bi][0] = acc_q[bi][0] + mbr_pkg::ACC_W'(tl);  // [RULE10] [RULE16]
        acc_d[bi][1] = acc_q[bi][1] + mbr_pkg::ACC_W'(tr);
        idx_d = idx_q + 5'h01;
        if (idx_q == mbr_pkg::LAST_IDX)
          st_d = mbr_pkg::ST_DONE;
      end
      // Publish clipped bus results
      mbr_pkg::ST_DONE:
      begin
        for (int k = 0; k < mbr_pkg::NAUX; k++)
        begin
          auxl_d[k] = bus_sat[k + 1][0];
          auxr_d[k] = bus_sat[k + 1][1];
        end
        monl_d = ml;
        monr_d = mr;
        hpl_d  = ctrl_q[mbr_pkg::CB_HPCUE] ? bus_sat[mbr_pkg::BUS_CUE][0] : bus_sat[mbr_pkg::BUS_MON][0];  // [RULE13]
        hpr_d  = ctrl_q[mbr_pkg::CB_HPCUE] ? bus_sat[mbr_pkg::BUS_CUE][1] : bus_sat[mbr_pkg::BUS_MON][1];  // [RULE13]
        st_d   = mbr_pkg::ST_IDLE;
      end
    endcase
  end

  // Mix engine flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= mbr_pkg::ST_IDLE;
      idx_q   <= 5'h00;
      acc_q   <= '{default: '0};
      smp_q   <= '{default: '0};
      msend_q <= '{default: '0};
      isend_q <= '{default: '0};
      rec_q   <= '{default: '0};
      auxl_q  <= '{default: '0};
      auxr_q  <= '{default: '0};
      monl_q  <= 16'sh0000;
      monr_q  <= 16'sh0000;
      hpl_q   <= 16'sh0000;
      hpr_q   <= 16'sh0000;
    end
    else
    begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      acc_q   <= acc_d;
      smp_q   <= smp_d;
      msend_q <= msend_d;
      isend_q <= isend_d;
      rec_q   <= rec_d;
      auxl_q  <= auxl_d;
      auxr_q  <= auxr_d;
      monl_q  <= monl_d;
      monr_q  <= monr_d;
      hpl_q   <= hpl_d;
      hpr_q   <= hpr_d;
    end
  end

  // Ports from flops
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign model_send = msend_q;
  assign ins_send   = isend_q;
  assign rec_out    = rec_q;
  assign aux_l      = auxl_q;
  assign aux_r      = auxr_q;
  assign mon_l      = monl_q;
  assign mon_r      = monr_q;
  assign hp_l       = hpl_q;
  assign hp_r       = hpr_q;

  // Checks
  hp_source_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE13]
    (st_q == mbr_pkg::ST_DONE && !ctrl_q[mbr_pkg::CB_HPCUE]) |=> hp_l == $past(bus_sat[0][0]))
    else $error("headphones not on monitor mix");
  mon_cue_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE14]
    (st_q == mbr_pkg::ST_DONE && ctrl_q[11:9] == 3'h1) |=> mon_r == $past(bus_sat[3][1]))
    else $error("monitor not on cue bus");
  mon_mute_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE18]
    (st_q == mbr_pkg::ST_DONE && ctrl_q[mbr_pkg::CB_MUTE]) |=> (mon_l == 16'sh0000 && mon_r == 16'sh0000))
    else $error("monitor mute failed");
  rec_wet_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE7]
    (st_q == mbr_pkg::ST_IDLE && sample_tick && eff_wet[2]) |=> rec_out[2] == $past(ins_ret[2]))
    else $error("wet record tap wrong");
  rec_model_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE8]
    (st_q == mbr_pkg::ST_IDLE && sample_tick && !eff_wet[0] && model_occupied[0])
      |=> rec_out[0] == $past(model_ret[0]))
    else $error("modelling slot not recorded");
  inst_jack_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE3]
    (st_q == mbr_pkg::ST_IDLE && sample_tick && inst_plug) |=> model_send[0] == $past(instrument_input))
    else $error("instrument jack not selected");
  src_hold_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE2]
    (!wr_en && panel_stb == 2'h0) |=> $stable(ctrl_q[1:0]))
    else $error("source changed without command");
  mix_clip_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE19]
    (st_q == mbr_pkg::ST_DONE && acc_q[0][0] > mbr_pkg::ACC_MAX && !ctrl_q[mbr_pkg::CB_HPCUE])
      |=> hp_l == mbr_pkg::S_MAX)
    else $error("bus sum wrapped");
  glob_rec_a : assert property (@(posedge pclk) disable iff (!presetn)  // [RULE9]
    (st_q == mbr_pkg::ST_IDLE && sample_tick && ctrl_q[7:6] == 2'h1) |=> rec_out[3] == $past(virt_in[1]))
    else $error("global dry override ignored");

endmodule : mbr_mixer

//--- verif/mbr_host_model.sv
`timescale 1ns/100ps
// Host side: plug-in processing in the slots and playback delivery
module mbr_host_model #(
  parameter logic signed [15:0] MODEL_ADD = 16'sh0032,  // Modelling plug-in offset
  parameter logic signed [15:0] INS_ADD   = 16'sh03e8   // Insert chain offset
) (
  // Modelling slot
  input  wire logic signed [15:0] model_send [2],
  output logic signed [15:0]      model_ret [2],
  // Standard insert chains
  input  wire logic signed [15:0] ins_send [4],
  output logic signed [15:0]      ins_ret [4],
  // Host playback stream
  input  wire logic signed [15:0] play [2],
  output logic signed [15:0]      virt_in [2]
);
  // Each processor adds a fixed offset so its presence shows in the data
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      model_ret[i] = model_send[i] + MODEL_ADD;
      virt_in[i]   = play[i];
    end
    for (int i = 0; i < 4; i++)
    begin
      ins_ret[i] = ins_send[i] + INS_ADD;
    end
  end
endmodule : mbr_host_model

//--- verif/mbr_mixer_tb_top.sv
`timescale 1ns/100ps
module mbr_mixer_tb_top;
  // Clock, reset and bookkeeping
  logic                      pclk;
  logic                      presetn;
  int                        num_errors;
  int                        n_tests;
  int                        cycles;
  // APB master side
  logic [7:0]                paddr;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  // Audio side
  logic                      sample_tick;
  logic                      inst_plug;
  logic [1:0]                panel_stb;
  logic [1:0]                panel_line;
  logic [1:0]                model_occupied;
  logic signed [15:0]        instrument_input;
  logic signed [15:0]        mic_in [2];
  logic signed [15:0]        line_in [2];
  logic signed [15:0]        play [2];
  logic signed [15:0]        virt_in [2];
  logic signed [15:0]        model_ret [2];
  logic signed [15:0]        model_send [2];
  logic signed [15:0]        ins_ret [4];
  logic signed [15:0]        ins_send [4];
  logic signed [15:0]        aux_ret_l [2];
  logic signed [15:0]        aux_ret_r [2];
  logic signed [15:0]        rec_out [4];
  logic signed [15:0]        aux_l [2];
  logic signed [15:0]        aux_r [2];
  logic signed [15:0]        mon_l;
  logic signed [15:0]        mon_r;
  logic signed [15:0]        hp_l;
  logic signed [15:0]        hp_r;

  // Block under test
  mbr_mixer u_mbr_mixer (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(sample_tick), .mic_in(mic_in), .line_in(line_in), .instrument_input(instrument_input),
    .inst_plug(inst_plug), .panel_stb(panel_stb), .panel_line(panel_line), .virt_in(virt_in),
    .model_occupied(model_occupied), .model_ret(model_ret), .model_send(model_send), .ins_ret(ins_ret),
    .ins_send(ins_send), .aux_ret_l(aux_ret_l), .aux_ret_r(aux_ret_r), .rec_out(rec_out), .aux_l(aux_l),
    .aux_r(aux_r), .mon_l(mon_l), .mon_r(mon_r), .hp_l(hp_l), .hp_r(hp_r));

  // Host processing and playback
  mbr_host_model u_mbr_host_model (.model_send(model_send), .model_ret(model_ret), .ins_send(ins_send),
    .ins_ret(ins_ret), .play(play), .virt_in(virt_in));

  // Clock generator
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Verdict and end of run
  task summarize;
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // Compare one value and count it
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer, held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      num_errors++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write expecting no error
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask : wr

  // Register read with expected data and error flag
  task rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk("read error", {31'h0, ex}, {31'h0, e});
  endtask : rd

  // Three frames, so registered sends settle through the host processing
  task frame;
    repeat (3)
    begin
      @(posedge pclk);
      sample_tick <= 1'b1;
      @(posedge pclk);
      sample_tick <= 1'b0;
      repeat (30) @(posedge pclk);
    end
  endtask : frame

  // Reset values, unmapped, misaligned and read-only places
  task t_regs;
    rd("control", mbr_pkg::CTRL_OFF, 32'h0, 1'b0);
    for (int k = 0; k < 24; k++)
      rd("entry", 8'(8'h40 + 4 * k), {15'h0, mbr_pkg::TAB_RST}, 1'b0);
    rd("unmapped", 8'h08, 32'h0, 1'b1);
    rd("misaligned", 8'h41, 32'h0, 1'b1);
    wr(mbr_pkg::STAT_OFF, 32'h3);
    rd("status", mbr_pkg::STAT_OFF, 32'h0, 1'b0);
  endtask : t_regs

  // Mic, line, panel command and instrument jack
  task t_source;
    mic_in           <= '{16'sh0064, 16'sh006e};
    line_in          <= '{16'sh00c8, 16'sh00d2};
    instrument_input <= 16'sh012c;
    frame;
    chk("pre1 mic", 32'h64, model_send[0]);
    wr(mbr_pkg::CTRL_OFF, 32'h1);
    frame;
    chk("pre1 line", 32'hc8, model_send[0]);
    chk("pre2 kept", 32'h6e, model_send[1]);
    @(posedge pclk);
    panel_line <= 2'h2;
    panel_stb  <= 2'h2;
    @(posedge pclk);
    panel_stb  <= 2'h0;
    frame;
    chk("pre2 panel", 32'hd2, model_send[1]);
    chk("pre1 kept", 32'hc8, model_send[0]);
    inst_plug <= 1'b1;
    frame;
    chk("pre1 inst", 32'h12c, model_send[0]);
    rd("status plug", mbr_pkg::STAT_OFF, 32'h1, 1'b0);
    inst_plug <= 1'b0;
    frame;
    chk("pre1 back", 32'hc8, model_send[0]);
  endtask : t_source

  // Modelling slot order, record taps and global override
  task t_record;
    wr(mbr_pkg::CTRL_OFF, 32'h0);
    model_occupied <= 2'h1;
    play           <= '{16'sh004d, 16'sh004d};
    frame;
    chk("insert send", 32'h96, ins_send[0]);
    chk("dry rec", 32'h96, rec_out[0]);
    chk("virt send", 32'h4d, ins_send[2]);
    chk("virt rec", 32'h4d, rec_out[2]);
    wr(mbr_pkg::CTRL_OFF, 32'h4);
    frame;
    chk("wet rec", 32'h47e, rec_out[0]);
    chk("own dry", 32'h6e, rec_out[1]);
    wr(mbr_pkg::CTRL_OFF, 32'h7c);
    frame;
    chk("global dry", 32'h96, rec_out[0]);
    wr(mbr_pkg::CTRL_OFF, 32'hc0);
    frame;
    chk("global wet", 32'h456, rec_out[1]);
    model_occupied <= 2'h0;
  endtask : t_record

  // Bus sends, taps, headphone and monitor selection, clipping
  task t_mix;
    wr(mbr_pkg::CTRL_OFF, 32'h0);
    mic_in <= '{16'sh0018, 16'shfc18};
    play   <= '{16'shfc18, 16'shfc18};
    wr(8'h40, 32'h00080);
    wr(8'h44, 32'h00080);
    wr(8'h4c, 32'h0ff80);
    frame;
    chk("mon left", 32'h1fe, mon_l);
    chk("mon right", 32'h0, mon_r);
    chk("hp mix", 32'h1fe, hp_l);
    chk("aux post", 32'hff, aux_l[0]);
    chk("aux2 left", 32'hbe, aux_l[1]);
    chk("aux2 right", 32'hc0, aux_r[1]);
    wr(8'h40, 32'h10080);
    wr(mbr_pkg::CTRL_OFF, 32'h100);
    frame;
    chk("mon muted", 32'h0, mon_l);
    chk("aux muted", 32'h0, aux_l[0]);
    chk("cue left", 32'h0, hp_l);
    chk("cue right", 32'h1fe, hp_r);
    wr(mbr_pkg::CTRL_OFF, 32'h200);
    frame;
    chk("mon cue", 32'h1fe, mon_r);
    chk("hp mix muted", 32'h0, hp_l);
    wr(mbr_pkg::CTRL_OFF, 32'h5b00);
    frame;
    chk("aux pre", 32'h1fe, aux_l[0]);
    chk("link left", 32'h1fe, hp_l);
    chk("link right", 32'h0, hp_r);
    chk("mono left", 32'hff, mon_l);
    chk("mono right", 32'hff, mon_r);
    wr(mbr_pkg::CTRL_OFF, 32'h5f00);
    frame;
    chk("mon mute", 32'h0, mon_l);
    chk("hp unmuted", 32'h1fe, hp_l);
    wr(mbr_pkg::CTRL_OFF, 32'h0);
    wr(8'h40, {15'h0, mbr_pkg::TAB_RST});
    mic_in <= '{16'sh7c17, 16'sh7c17};
    play   <= '{16'sh7c17, 16'sh7c17};
    frame;
    chk("clip high", 32'h7fff, mon_l);
    mic_in <= '{16'sh8300, 16'sh8300};
    play   <= '{16'sh8300, 16'sh8300};
    frame;
    chk("clip low", 32'hffff8000, mon_r);
  endtask : t_mix

  // Cut a hang short
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      summarize;
    end
  end

  // Main sequence
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    cycles = 0;
    presetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    {sample_tick, inst_plug, panel_stb, panel_line, model_occupied} = '0;
    instrument_input = '0;
    mic_in = '{default: '0};
    line_in = '{default: '0};
    play = '{default: '0};
    aux_ret_l = '{default: '0};
    aux_ret_r = '{default: '0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_source;
    t_record;
    t_mix;
    summarize;
  end
endmodule : mbr_mixer_tb_top
